// ===== shared/fbm_pkg.sv
package fbm_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	// overall-reset timing, printed figures in their own units
	localparam int unsigned ARM_HOLD_S = 9;
	localparam int unsigned STEADY_S = 3;
	localparam int unsigned RETIP_S = 3;
	localparam int unsigned BLINK_MS = 250;
	localparam int unsigned DEBOUNCE_US = 10_000;
	localparam int unsigned ARM_HOLD_CYC = ARM_HOLD_S * CLK_HZ;
	localparam int unsigned STEADY_CYC = STEADY_S * CLK_HZ;
	localparam int unsigned RETIP_CYC = RETIP_S * CLK_HZ;
	localparam int unsigned BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
	localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned BLINK_COUNT = 3;
	localparam int unsigned MAX_SLAVES = 16;
	// built-in default bus parameters
	localparam logic [6:0] DEF_STATION = 7'h01;
	localparam logic [3:0] RATE_1M5 = 4'h6;
	// wishbone register map, byte addresses
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_IRQ_STAT = 4'h8;
	localparam logic [3:0] REG_IRQ_MASK = 4'hc;
	// ctrl fields
	localparam int unsigned CTL_CFG_VALID = 0;
	localparam int unsigned CTL_CFG_LOAD = 1;
	localparam int unsigned CTL_CARD = 2;
	localparam int unsigned CTL_SLV_LSB = 8;
	localparam int unsigned CTL_STA_LSB = 16;
	localparam int unsigned CTL_RATE_LSB = 24;
	// irq / event bits
	localparam int unsigned EV_STOP = 0;
	localparam int unsigned EV_ERASE = 1;
	localparam int unsigned EV_CFG_ERR = 2;
	localparam int unsigned EV_SLV_FAIL = 3;
	localparam int unsigned EV_W = 4;
	localparam logic [31:0] CTRL_RST = 32'h0;
	localparam logic [EV_W-1:0] MASK_RST = 4'h0;
	typedef enum logic [1:0] {fbm_lev_halt, fbm_lev_run, fbm_lev_mres} fbm_lever_e;
endpackage

// ===== rtl/fbm_ctrl.sv
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/10ps
// Operation
// - completed overall-reset erases stored configuration
// - card blinks thrice, steady, init-fault blinks
// - re-tip within three seconds then erase
// - erase ok: success blinks, init-fault steady
// - run after erase reboots with defaults
// - defaults: station one, 1.5 megabaud
// - valid host configuration loaded at power-up; ctrl resets to zero, so it loads on a CTL_CFG_LOAD write or lever to run
// - at most sixteen slaves, else reject
// - failure lamp on any slave failure while in run
// - run clear state: run lamp only
// - operate: run and traffic lamps
// - traffic lamp follows bus activity while in run with slaves accessed
// - init-fault lamp on invalid parameters
// - run position with valid parameters runs
// - halt position stops, outputs forced zero
// - lever stop raises alarm upward
// - bad parameters: stay stopped, defaults, fault
module fbm_ctrl
#(
	parameter int unsigned HOLD_CYC = fbm_pkg::ARM_HOLD_CYC,
	parameter int unsigned STEADY_CYCLES = fbm_pkg::STEADY_CYC,
	parameter int unsigned RETIP_CYCLES = fbm_pkg::RETIP_CYC,
	parameter int unsigned BLINK_CYCLES = fbm_pkg::BLINK_CYC,
	parameter int unsigned DEB_CYC = fbm_pkg::DEBOUNCE_CYC
)
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic run_position,
	input wire logic halt_position,
	input wire logic memory_reset_position,
	input wire logic slave_failed,
	input wire logic bus_activity,
	input wire logic slaves_accessed,
	output logic card_lamp,
	output logic init_fault_lamp,
	output logic success_lamp,
	output logic slave_failure_lamp,
	output logic traffic_lamp,
	output logic run_lamp,
	output logic comm_enable,
	output logic outputs_zero,
	output logic erase_flash,
	output logic alarm,
	output logic [6:0] station_addr,
	output logic [3:0] baud_sel,
	output logic irq
);
	import fbm_pkg::*;

	// length of a three-blink burst
	localparam int unsigned BLINK_SPAN = 2 * BLINK_COUNT * BLINK_CYCLES;

	typedef enum logic [3:0] {
		fbm_boot, fbm_stop, fbm_run, fbm_mr_blink_card, fbm_mr_steady,
		fbm_mr_blink_fault, fbm_mr_armed, fbm_mr_wait_tip, fbm_erase_ok
	} fbm_state_e;

	typedef struct packed {
		fbm_state_e st;
		logic [2:0] s1;
		logic [2:0] s2;
		fbm_lever_e lev;
		logic [31:0] deb;
		logic [31:0] tmr;
		logic [31:0] bt;
		logic hold_off;
		logic blink_on;
		logic [31:0] ctrl;
		logic [EV_W-1:0] ists;
		logic [EV_W-1:0] imask;
		logic cfg_ok;
		logic [6:0] sta;
		logic [3:0] rate;
		logic erase;
		logic alarm;
		logic fail_d;
		logic ack;
		logic [31:0] rdat;
	} fbm_s;

	fbm_s r_q, r_d;

	function automatic fbm_lever_e lever_of(input logic [2:0] s);
		if (s[2])
			return fbm_lev_mres;
		else if (s[1])
			return fbm_lev_halt;
		else if (s[0])
			return fbm_lev_run;
		else
			return fbm_lev_halt;
	endfunction

	function automatic logic cfg_good(input logic [31:0] c);
		return c[CTL_CFG_VALID] && c[CTL_CARD] && (c[CTL_SLV_LSB +: 5] <= 5'(MAX_SLAVES));
	endfunction

	logic [2:0] raw_lever;
	fbm_lever_e lev_raw;
	logic wb_hit;
	logic [EV_W-1:0] ev;

	assign raw_lever = {memory_reset_position, halt_position, run_position};
	assign wb_hit = wb_cyc_i && wb_stb_i && !r_q.ack;

	always_comb
	begin
		r_d = r_q;
		ev = '0;
		r_d.erase = 1'b0;
		r_d.alarm = 1'b0;
		r_d.ack = wb_hit;
		r_d.s1 = raw_lever;
		r_d.s2 = r_q.s1;
		lev_raw = lever_of(r_q.s2);
		// lever debounce
		if (lev_raw != r_q.lev)
		begin
			if (r_q.deb >= DEB_CYC - 1)
			begin
				r_d.lev = lev_raw;
				r_d.deb = '0;
			end
			else
				r_d.deb = r_q.deb + 32'h1;
		end
		else
			r_d.deb = '0;
		r_d.tmr = r_q.tmr + 32'h1;
		if (r_q.bt >= BLINK_CYCLES - 1)
		begin
			r_d.bt = '0;
			r_d.blink_on = !r_q.blink_on;
		end
		else
			r_d.bt = r_q.bt + 32'h1;
		// a bad boot with the lever at run must not reboot again until the lever moves
		if (r_q.lev != fbm_lev_run)
			r_d.hold_off = 1'b0;
		case (r_q.st)
			fbm_boot:
			begin
				// load host configuration, fall back to defaults
				r_d.cfg_ok = cfg_good(r_q.ctrl);
				if (cfg_good(r_q.ctrl))
				begin
					r_d.sta = r_q.ctrl[CTL_STA_LSB +: 7];
					r_d.rate = r_q.ctrl[CTL_RATE_LSB +: 4];
				end
				else
				begin
					r_d.sta = DEF_STATION;
					r_d.rate = RATE_1M5;
					ev[EV_CFG_ERR] = 1'b1;
					r_d.hold_off = 1'b1;
				end
				r_d.st = (cfg_good(r_q.ctrl) && r_q.lev == fbm_lev_run) ? fbm_run : fbm_stop;
			end
			fbm_stop:
			begin
				if (r_q.lev == fbm_lev_run && !r_q.hold_off)
					r_d.st = fbm_boot;
				else if (r_q.lev == fbm_lev_mres)
				begin
					r_d.st = fbm_mr_blink_card;
					r_d.tmr = '0;
					// restart the blink phase so the burst is exactly three
					r_d.bt = '0;
					r_d.blink_on = 1'b1;
				end
			end
			fbm_run:
			begin
				if (r_q.lev != fbm_lev_run)
				begin
					r_d.st = fbm_stop;
					r_d.alarm = 1'b1;
					ev[EV_STOP] = 1'b1;
				end
			end
			fbm_mr_blink_card, fbm_mr_steady, fbm_mr_blink_fault:
			begin
				// hold sequence, abandoned if the lever leaves early
				if (r_q.lev != fbm_lev_mres)
					r_d.st = fbm_stop;
				else if (r_q.tmr >= HOLD_CYC - 1)
					r_d.st = fbm_mr_armed;
				else if (r_q.st == fbm_mr_blink_card && r_q.tmr >= BLINK_SPAN - 1)
					r_d.st = fbm_mr_steady;
				else if (r_q.st == fbm_mr_steady && r_q.tmr >= BLINK_SPAN + STEADY_CYCLES - 1)
				begin
					r_d.st = fbm_mr_blink_fault;
					r_d.bt = '0;
					r_d.blink_on = 1'b1;
				end
			end
			fbm_mr_armed:
			begin
				if (r_q.lev != fbm_lev_mres)
				begin
					r_d.st = fbm_mr_wait_tip;
					r_d.tmr = '0;
				end
			end
			fbm_mr_wait_tip:
			begin
				if (r_q.lev == fbm_lev_mres)
				begin
					r_d.erase = 1'b1;
					r_d.st = fbm_erase_ok;
					r_d.tmr = '0;
					r_d.cfg_ok = 1'b0;
					r_d.ctrl = CTRL_RST;
					r_d.sta = DEF_STATION;
					r_d.rate = RATE_1M5;
					r_d.bt = '0;
					r_d.blink_on = 1'b1;
					ev[EV_ERASE] = 1'b1;
				end
				else if (r_q.tmr >= RETIP_CYCLES - 1)
					r_d.st = fbm_stop;
			end
			fbm_erase_ok:
			begin
				if (r_q.lev == fbm_lev_run)
					r_d.st = fbm_boot;
			end
			default:
				r_d.st = fbm_boot;
		endcase
		r_d.fail_d = slave_failed;
		if (slave_failed && !r_q.fail_d)
		begin
			ev[EV_SLV_FAIL] = 1'b1;
			if (r_q.st == fbm_run)
				r_d.alarm = 1'b1;
		end
		// wishbone slave
		r_d.rdat = '0;
		if (wb_hit && !wb_we_i)
		begin
			case (wb_adr_i)
				REG_CTRL: r_d.rdat = r_q.ctrl;
				REG_STATUS: r_d.rdat = {16'h0, r_q.sta, r_q.rate, r_q.cfg_ok, r_q.st};
				REG_IRQ_STAT: r_d.rdat = {28'h0, r_q.ists};
				REG_IRQ_MASK: r_d.rdat = {28'h0, r_q.imask};
				default: r_d.rdat = '0;
			endcase
		end
		if (wb_hit && !wb_we_i && wb_adr_i == REG_IRQ_STAT)
			r_d.ists = ev;
		else
			r_d.ists = r_q.ists | ev;
		if (wb_hit && wb_we_i)
		begin
			if (wb_adr_i == REG_CTRL)
			begin
				for (int i = 0; i < 4; i++)
					if (wb_sel_i[i])
						r_d.ctrl[8*i +: 8] = wb_dat_i[8*i +: 8];
				if (wb_sel_i[0] && wb_dat_i[CTL_CFG_LOAD] && r_q.st == fbm_stop)
					r_d.st = fbm_boot;
			end
			if (wb_adr_i == REG_IRQ_MASK && wb_sel_i[0])
				r_d.imask = wb_dat_i[EV_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			r_q <= '0;
			r_q.st <= fbm_boot;
			r_q.lev <= fbm_lev_halt;
			r_q.ctrl <= CTRL_RST;
			r_q.imask <= MASK_RST;
			r_q.sta <= DEF_STATION;
			r_q.rate <= RATE_1M5;
		end
		else
			r_q <= r_d;
	end

	always_comb
	begin
		card_lamp = 1'b0;
		init_fault_lamp = !r_q.cfg_ok;
		success_lamp = 1'b0;
		run_lamp = 1'b0;
		traffic_lamp = 1'b0;
		case (r_q.st)
			fbm_mr_blink_card: card_lamp = r_q.blink_on;
			fbm_mr_steady: card_lamp = 1'b1;
			fbm_mr_blink_fault: init_fault_lamp = r_q.blink_on || r_q.tmr >= 2 * BLINK_SPAN + STEADY_CYCLES;
			fbm_mr_armed, fbm_mr_wait_tip: init_fault_lamp = 1'b1;
			fbm_erase_ok:
			begin
				success_lamp = r_q.blink_on && r_q.tmr < BLINK_SPAN;
				init_fault_lamp = 1'b1;
			end
			fbm_run:
			begin
				run_lamp = 1'b1;
				traffic_lamp = slaves_accessed && bus_activity;
			end
			default: ;
		endcase
	end

	assign slave_failure_lamp = slave_failed && r_q.st == fbm_run;
	assign comm_enable = r_q.st == fbm_run;
	assign outputs_zero = r_q.st != fbm_run;
	assign erase_flash = r_q.erase;
	assign alarm = r_q.alarm;
	assign station_addr = r_q.sta;
	assign baud_sel = r_q.rate;
	assign wb_ack_o = r_q.ack;
	assign wb_dat_o = r_q.rdat;
	assign irq = |(r_q.ists & r_q.imask);

	a_stop_alarm: assert property (@(posedge core_clk) disable iff (!nrst)
		(r_q.st == fbm_run && r_d.st == fbm_stop) |=> alarm)
		else $error("stop from run without alarm");
	a_stop_zero: assert property (@(posedge core_clk) disable iff (!nrst)
		(r_q.st == fbm_stop) |-> (outputs_zero && !comm_enable))
		else $error("outputs not zero in stop");
	a_erase_lamp: assert property (@(posedge core_clk) disable iff (!nrst)
		erase_flash |-> (init_fault_lamp && r_q.st == fbm_erase_ok))
		else $error("erase without fault lamp");
	a_erase_armed: assert property (@(posedge core_clk) disable iff (!nrst)
		erase_flash |-> $past(r_q.st) == fbm_mr_wait_tip)
		else $error("erase without armed re-tip");
	a_default_par: assert property (@(posedge core_clk) disable iff (!nrst)
		(r_q.st != fbm_boot && !r_q.cfg_ok) |-> (station_addr == DEF_STATION && baud_sel == RATE_1M5))
		else $error("defaults not applied");
	a_fail_lamp: assert property (@(posedge core_clk) disable iff (!nrst)
		(slave_failed && r_q.st == fbm_run) |-> slave_failure_lamp)
		else $error("failure lamp off");
	a_run_lamp: assert property (@(posedge core_clk) disable iff (!nrst)
		(r_q.st == fbm_run && !bus_activity) |-> (run_lamp && !traffic_lamp))
		else $error("run lamp pattern wrong");
	a_bad_cfg: assert property (@(posedge core_clk) disable iff (!nrst)
		(r_q.st == fbm_boot && !cfg_good(r_q.ctrl)) |=> (r_q.st == fbm_stop && init_fault_lamp))
		else $error("bad config entered run");
	a_irq_set_wins: assert property (@(posedge core_clk) disable iff (!nrst)
		(ev != '0) |=> ((r_q.ists & $past(ev)) == $past(ev)))
		else $error("event lost against status read");

	sequence fbm_armed_left;
		r_q.st == fbm_mr_armed && r_q.lev != fbm_lev_mres;
	endsequence
	sequence fbm_tip_open;
		r_q.st == fbm_mr_wait_tip && r_q.tmr == '0;
	endsequence

	a_arm_release: assert property (@(posedge core_clk) disable iff (!nrst)
		fbm_armed_left |=> fbm_tip_open)
		else $error("release after arming did not open re-tip window");
	a_success_start: assert property (@(posedge core_clk) disable iff (!nrst)
		erase_flash |-> (success_lamp && station_addr == DEF_STATION))
		else $error("erase without success blink");
	a_card_steady: assert property (@(posedge core_clk) disable iff (!nrst)
		(r_q.st == fbm_mr_steady) |-> (card_lamp && r_q.tmr >= BLINK_SPAN && r_q.tmr < BLINK_SPAN + STEADY_CYCLES))
		else $error("card steady phase out of window");
endmodule

// ===== dv/fbm_lever_model.sv
`timescale 1ns/10ps
module fbm_lever_model
	import fbm_pkg::*;
(
	input wire fbm_pkg::fbm_lever_e pos,
	output logic run_position,
	output logic halt_position,
	output logic memory_reset_position
);
	// three-position lever, exactly one contact closed at a time
	assign run_position = (pos == fbm_lev_run);
	assign halt_position = (pos == fbm_lev_halt);
	assign memory_reset_position = (pos == fbm_lev_mres);
endmodule

// ===== dv/fieldbus_master_mode_control_bench.sv
`timescale 1ns/10ps
module fieldbus_master_mode_control_bench;
	import fbm_pkg::*;
	logic core_clk, nrst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
	logic [3:0] wb_adr_i, wb_sel_i, baud_sel;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic run_position, halt_position, memory_reset_position, slave_failed, bus_activity, slaves_accessed;
	logic card_lamp, init_fault_lamp, success_lamp, slave_failure_lamp, traffic_lamp, run_lamp;
	logic comm_enable, outputs_zero, erase_flash, alarm, irq, card_p, ok_p;
	logic [6:0] station_addr;
	fbm_lever_e pos;
	int err_total = 0;
	int samples_checked = 0;
	int alarms = 0;
	int erases = 0;
	int card_rises = 0;
	int ok_rises = 0;
	int n;

	fbm_ctrl #(.HOLD_CYC(600), .STEADY_CYCLES(200), .RETIP_CYCLES(200), .BLINK_CYCLES(20), .DEB_CYC(4)) uut (
		.core_clk, .nrst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i,
		.wb_ack_o, .run_position, .halt_position, .memory_reset_position, .slave_failed, .bus_activity,
		.slaves_accessed, .card_lamp, .init_fault_lamp, .success_lamp, .slave_failure_lamp, .traffic_lamp,
		.run_lamp, .comm_enable, .outputs_zero, .erase_flash, .alarm, .station_addr, .baud_sel, .irq);
	fbm_lever_model lever (.pos, .run_position, .halt_position, .memory_reset_position);

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// pulse and blink counters
	always @(posedge core_clk)
	begin
		card_p <= card_lamp;
		ok_p <= success_lamp;
		if (alarm === 1'b1) alarms <= alarms + 1;
		if (erase_flash === 1'b1) erases <= erases + 1;
		if (card_lamp === 1'b1 && card_p !== 1'b1) card_rises <= card_rises + 1;
		if (success_lamp === 1'b1 && ok_p !== 1'b1) ok_rises <= ok_rises + 1;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// classic wishbone single cycle, entered right after an edge
	task wb(input logic [3:0] a, input logic w, input logic [31:0] d);
		int k;
		k = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_adr_i <= a;
		wb_we_i <= w;
		wb_dat_i <= d;
		do
		begin
			@(posedge core_clk);
			k++;
		end
		while (wb_ack_o !== 1'b1 && k < 50);
		chk(wb_ack_o, 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wait_lv(ref logic s, input logic v);
		int k;
		k = 0;
		while (s !== v && k < 3000)
		begin
			@(posedge core_clk);
			k++;
		end
		chk(s, v);
	endtask

	task cyc(input int c);
		repeat (c) @(posedge core_clk);
	endtask

	task results;
		if (err_total == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		results();
	end

	initial
	begin
		nrst = 1'b0;
		{wb_we_i, wb_cyc_i, wb_stb_i} = 3'h0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		pos = fbm_lev_halt;
		{slave_failed, bus_activity, slaves_accessed} = 3'h0;
		cyc(16);
		chk(init_fault_lamp, 1'b1);
		chk(station_addr, DEF_STATION);
		chk(baud_sel, RATE_1M5);
		nrst <= 1'b1;
		cyc(1);
		wb(REG_CTRL, 1'b0, 32'h0);
		chk(rd, CTRL_RST);
		wb(4'h2, 1'b1, 32'hffffffff);
		wb(4'h2, 1'b0, 32'h0);
		chk(rd, 32'h0);
		wb(REG_IRQ_MASK, 1'b1, 32'hf);
		wb(REG_IRQ_MASK, 1'b0, 32'h0);
		chk(rd, 32'hf);
		wb(REG_IRQ_STAT, 1'b0, 32'h0);
		// valid: 16 slaves, station 5, rate 2, card present
		wb(REG_CTRL, 1'b1, 32'h02051005);
		pos <= fbm_lev_run;
		wait_lv(comm_enable, 1'b1);
		chk(run_lamp, 1'b1);
		chk(outputs_zero, 1'b0);
		chk(station_addr, 7'h05);
		chk(baud_sel, 4'h2);
		slaves_accessed <= 1'b1;
		cyc(3);
		chk({run_lamp, traffic_lamp}, 2'b10);
		bus_activity <= 1'b1;
		cyc(3);
		chk({run_lamp, traffic_lamp}, 2'b11);
		slave_failed <= 1'b1;
		cyc(3);
		chk(slave_failure_lamp, 1'b1);
		chk(irq, 1'b1);
		wb(REG_IRQ_STAT, 1'b0, 32'h0);
		chk(rd[EV_SLV_FAIL], 1'b1);
		slave_failed <= 1'b0;
		bus_activity <= 1'b0;
		wb(REG_IRQ_STAT, 1'b0, 32'h0);
		chk(rd, 32'h0);
		chk(irq, 1'b0);
		chk(alarms, 1);
		n = alarms;
		pos <= fbm_lev_halt;
		wait_lv(comm_enable, 1'b0);
		cyc(3);
		chk(outputs_zero, 1'b1);
		chk(alarms, n + 1);
		wb(REG_IRQ_STAT, 1'b0, 32'h0);
		chk(rd[EV_STOP], 1'b1);
		// seventeen slaves is one too many
		wb(REG_CTRL, 1'b1, 32'h02051105);
		pos <= fbm_lev_run;
		cyc(200);
		chk(comm_enable, 1'b0);
		chk(init_fault_lamp, 1'b1);
		chk(station_addr, DEF_STATION);
		pos <= fbm_lev_halt;
		cyc(20);
		// reload a valid set, so the erase has something to clear
		wb(REG_CTRL, 1'b1, 32'h02071007);
		cyc(20);
		chk(station_addr, 7'h07);
		chk(init_fault_lamp, 1'b0);
		pos <= fbm_lev_mres;
		cyc(700);
		// three blinks, then the steady phase lights it once more
		chk(card_rises, 4);
		chk(init_fault_lamp, 1'b1);
		chk(erases, 0);
		pos <= fbm_lev_halt;
		cyc(30);
		pos <= fbm_lev_mres;
		cyc(300);
		chk(erases, 1);
		chk(ok_rises, 3);
		chk(station_addr, DEF_STATION);
		chk(init_fault_lamp, 1'b1);
		pos <= fbm_lev_halt;
		cyc(20);
		pos <= fbm_lev_run;
		cyc(200);
		chk(station_addr, DEF_STATION);
		chk(baud_sel, RATE_1M5);
		chk(comm_enable, 1'b0);
		results();
	end
endmodule
